/* File: hw/sld_linker.sv */
// Purpose: data registers and path linking of the scan linker
// Assumes: tap state, instruction choice and control bits come from
//          logic on clk_sys_in; test pins are asynchronous
// Notes:   all pin edges are seen through a three flop filter
//
// What this block does
// - path select register is eight bits; reset clears it, paths off
// - four two-bit fields, one per path, high bit is field msb
// - static mode-select levels take effect at Update-DR falling edge
// - follow lines switch at Update-DR when some line already follows
// - first follower held low until Run-Test/Idle falling edge
// - field 00 high, 01 low, msb set follows tms and enables data
// - downstream data driven only in Shift-IR or Shift-DR
// - pin capture chain is ten cells, untouched by reset
// - cell order: mci, mco, dci, ts en, od en, dco, id 4..1
// - identity cells scan alone as a four-bit chain
// - bypass is one bit, loads zero in Capture-DR
// - bypass is the selected register after power-up
// - enabled paths stay ahead of bypass in the chain
// - eight-bit shift plus counter; reset clears shift only
// - counter preloads from shift register, count read back through it
// - condition input edges clock counter; bit 1 picks edge
// - count-end flag low at end value for direction, else high
// - control bit 9 sets count direction, up after reset
// - bit 8 with down count holds at zero
// - bits 5 and 6 route count-end flag to condition output
// - paths chained 1 to 4, then internal register, then tdo
// - one flop of delay before each downstream data output
// - control bit 0 floats downstream clock, data, mode-select
`timescale 1ns/100ps
module sld_linker (
	input  wire logic                  clk_sys_in,
	input  wire logic                  reset_in,
	input  wire logic                  tck_in,
	input  wire logic                  tms_in,
	input  wire logic                  tdi_in,
	input  wire logic                  condition_input_in,
	input  wire logic [3:0]            downstream_data_in,
	input  wire logic [9:0]            pin_capture_in,
	input  wire logic [3:0]            tap_state_in,
	input  wire sld_pkg::sld_sel_e     dr_sel_in,
	input  wire logic [9:0]            control_chain_in,
	input  wire logic                  ext_tdo_in,
	output logic                       tdo_out,
	output logic                       tdo_oe_n_out,
	output logic                       downstream_test_clock_out,
	output logic                       downstream_test_clock_oe_n_out,
	output logic [3:0]                 downstream_mode_select_out,
	output logic                       dms_oe_n_out,
	output logic [3:0]                 downstream_data_out,
	output logic [3:0]                 ddo_oe_n_out,
	output logic [9:0]                 pin_force_out,
	output logic                       count_end_n_out,
	output logic                       condition_output_out,
	output logic                       preload_ready_out
);
	////////////////////////////////////////////////////////////////////
	// power-up value stands in for cells that reset must not touch
	sld_pkg::sld_st_s st_ff = '0;
	sld_pkg::sld_st_s nxt_st;

	logic [sld_pkg::PIN_W-1:0] pins;
	logic [sld_pkg::PIN_W-1:0] dif;
	logic [sld_pkg::NPATH:0]   link;
	logic [3:0]                en;
	logic [3:0]                nf;
	logic [3:0]                nl;
	logic                      tck_f;
	logic                      t_rise;
	logic                      t_fall;
	logic                      c_rise;
	logic                      c_fall;
	logic                      cnt_ev;
	logic                      sh_any;
	logic                      tail;
	logic                      down;
	logic                      hold0;
	logic                      drain;
	logic                      push;
	logic [9:0]                ctl;

	assign ctl  = control_chain_in;
	assign pins = {pin_capture_in, downstream_data_in, condition_input_in,
		tdi_in, tms_in, tck_in};
	// a bit counts only once flops two and three agree
	assign dif    = st_ff.s2 ^ st_ff.s3;
	assign tck_f  = st_ff.flt[sld_pkg::P_TCK];
	assign t_rise = tck_f & ~st_ff.pv[0];
	assign t_fall = ~tck_f & st_ff.pv[0];
	assign c_rise = st_ff.flt[sld_pkg::P_CND] & ~st_ff.pv[1];
	assign c_fall = ~st_ff.flt[sld_pkg::P_CND] & st_ff.pv[1];
	assign cnt_ev = ctl[sld_pkg::CTL_DCIP] ? c_rise : c_fall;
	assign sh_any = (tap_state_in == sld_pkg::TAP_SHDR)
		| (tap_state_in == sld_pkg::TAP_SHIR);
	assign down   = ctl[sld_pkg::CTL_DOWN];
	assign hold0  = ctl[sld_pkg::CTL_HOLD] & down
		& (st_ff.cnt == sld_pkg::CNT_MIN);
	// counting has priority; preload waits a cycle on an edge
	assign drain  = (st_ff.fill != 2'h0) & ~cnt_ev & ~reset_in;
	assign push   = t_fall & (tap_state_in == sld_pkg::TAP_UPDDR)
		& (st_ff.sel == sld_pkg::SEL_CNT) & (st_ff.fill != 2'h2);
	assign link[0] = st_ff.flt[sld_pkg::P_TDI];

	////////////////////////////////////////////////////////////////////
	// per path decode and chaining in ascending order
	genvar gi;
	generate
		for (gi = 0; gi < sld_pkg::NPATH; gi++) begin : g_path
			assign en[gi] = st_ff.ps[2*gi+1];
			assign nf[gi] = st_ff.ps_sh[2*gi+1];
			assign nl[gi] = ~st_ff.ps_sh[2*gi];
			assign link[gi+1] = en[gi] ?
				st_ff.flt[sld_pkg::P_DDI+gi] : link[gi];
		end
	endgenerate

	always_comb begin
		case (st_ff.sel)
			sld_pkg::SEL_BYP:  tail = st_ff.bp;
			sld_pkg::SEL_PATH: tail = st_ff.ps_sh[0];
			sld_pkg::SEL_PIN:  tail = st_ff.bsr_sh[0];
			sld_pkg::SEL_IDB:  tail = st_ff.bsr_sh[0];
			sld_pkg::SEL_CNT:  tail = st_ff.cnt_sh[0];
			default:           tail = ext_tdo_in;
		endcase
		if (tap_state_in == sld_pkg::TAP_SHIR)
			tail = ext_tdo_in;
	end

	////////////////////////////////////////////////////////////////////
	always_comb begin
		nxt_st = st_ff;
		nxt_st.s1 = pins;
		nxt_st.s2 = st_ff.s1;
		nxt_st.s3 = st_ff.s2;
		nxt_st.flt = (st_ff.s2 & ~dif) | (st_ff.flt & dif);
		nxt_st.pv = {st_ff.flt[sld_pkg::P_CND], tck_f};

		if (t_rise) begin
			nxt_st.stg = link[3:0];
			if (tap_state_in == sld_pkg::TAP_CAPDR) begin
				case (st_ff.sel)
					sld_pkg::SEL_BYP:  nxt_st.bp = 1'b0;
					sld_pkg::SEL_PATH: nxt_st.ps_sh = st_ff.ps;
					sld_pkg::SEL_PIN:  nxt_st.bsr_sh =
						st_ff.flt[sld_pkg::P_CAP +: 10];
					sld_pkg::SEL_IDB:  nxt_st.bsr_sh[3:0] =
						st_ff.flt[sld_pkg::P_CAP +: 4];
					sld_pkg::SEL_CNT:  nxt_st.cnt_sh = st_ff.cnt;
					default:           nxt_st.bp = st_ff.bp;
				endcase
			end
			if (tap_state_in == sld_pkg::TAP_SHDR) begin
				case (st_ff.sel)
					sld_pkg::SEL_BYP:  nxt_st.bp = link[4];
					sld_pkg::SEL_PATH: nxt_st.ps_sh =
						{link[4], st_ff.ps_sh[7:1]};
					sld_pkg::SEL_PIN:  nxt_st.bsr_sh =
						{link[4], st_ff.bsr_sh[9:1]};
					sld_pkg::SEL_IDB:  nxt_st.bsr_sh[3:0] =
						{link[4], st_ff.bsr_sh[3:1]};
					sld_pkg::SEL_CNT:  nxt_st.cnt_sh =
						{link[4], st_ff.cnt_sh[7:1]};
					default:           nxt_st.bp = st_ff.bp;
				endcase
			end
		end

		if (t_fall) begin
			nxt_st.tdo = sh_any ? tail : st_ff.tdo;
			nxt_st.tdo_oe_n = ~sh_any;
			nxt_st.ddo = st_ff.stg;
			if (tap_state_in == sld_pkg::TAP_UPDDR) begin
				case (st_ff.sel)
					sld_pkg::SEL_PATH: begin
						nxt_st.ps = st_ff.ps_sh;
						nxt_st.lvl = nl;
						if (|st_ff.fol) begin
							nxt_st.fol = nf;
							nxt_st.pend = 4'h0;
						end else begin
							nxt_st.fol = 4'h0;
							nxt_st.pend = nf;
						end
					end
					sld_pkg::SEL_PIN:  nxt_st.pin_capture_chain = st_ff.bsr_sh;
					sld_pkg::SEL_IDB:  nxt_st.pin_capture_chain[3:0] = st_ff.bsr_sh[3:0];
					default:           nxt_st.bp = st_ff.bp;
				endcase
			end
			if (tap_state_in == sld_pkg::TAP_UPDIR)
				nxt_st.sel = dr_sel_in;
			if (tap_state_in == sld_pkg::TAP_RTI) begin
				nxt_st.fol = st_ff.fol | st_ff.pend;
				nxt_st.pend = 4'h0;
			end
		end

		// two-entry preload buffer between scan side and counter
		if (push) begin
			nxt_st.bufm[st_ff.wp] = st_ff.cnt_sh;
			nxt_st.wp = ~st_ff.wp;
		end
		if (drain) begin
			nxt_st.cnt = st_ff.bufm[st_ff.rp];
			nxt_st.rp = ~st_ff.rp;
		end else if (cnt_ev && !hold0) begin
			nxt_st.cnt = down ? st_ff.cnt - 8'h01
				: st_ff.cnt + 8'h01;
		end
		nxt_st.fill = st_ff.fill + {1'b0, push} - {1'b0, drain};

		// pin side outputs, all registered
		nxt_st.dms = (st_ff.fol & {4{st_ff.flt[sld_pkg::P_TMS]}})
			| (~st_ff.fol & ~st_ff.pend & st_ff.lvl);
		nxt_st.dms_oe_n = ctl[sld_pkg::CTL_OFF];
		nxt_st.downstream_test_clock = tck_f;
		nxt_st.downstream_test_clock_oe_n = ctl[sld_pkg::CTL_OFF];
		nxt_st.ddo_oe_n = ~(en & {4{sh_any & ~ctl[sld_pkg::CTL_OFF]}});
		nxt_st.ce_n = ~(down ? st_ff.cnt == sld_pkg::CNT_MIN
			: st_ff.cnt == sld_pkg::CNT_MAX);
		case (ctl[sld_pkg::CTL_SRC1:sld_pkg::CTL_SRC0])
			2'h2:    nxt_st.condition_output = st_ff.ce_n ^ ctl[sld_pkg::CTL_POL];
			2'h3:    nxt_st.condition_output = st_ff.flt[sld_pkg::P_CND]
				^ ctl[sld_pkg::CTL_POL] ^ ctl[sld_pkg::CTL_DCIP];
			default: nxt_st.condition_output = ~ctl[sld_pkg::CTL_POL];
		endcase

		// pin cells and counter value deliberately survive reset
		if (reset_in) begin
			nxt_st.ps_sh = sld_pkg::PS_RST;
			nxt_st.ps = sld_pkg::PS_RST;
			nxt_st.lvl = sld_pkg::LVL_RST;
			nxt_st.fol = 4'h0;
			nxt_st.pend = 4'h0;
			nxt_st.sel = sld_pkg::SEL_BYP;
			nxt_st.bp = 1'b0;
			nxt_st.cnt_sh = 8'h00;
			nxt_st.wp = 1'b0;
			nxt_st.rp = 1'b0;
			nxt_st.fill = 2'h0;
			nxt_st.tdo = 1'b0;
			nxt_st.tdo_oe_n = 1'b1;
			nxt_st.ddo = 4'h0;
			nxt_st.ddo_oe_n = 4'hF;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		st_ff <= nxt_st;
	end

	assign tdo_out                    = st_ff.tdo;
	assign tdo_oe_n_out               = st_ff.tdo_oe_n;
	assign downstream_test_clock_out  = st_ff.downstream_test_clock;
	assign downstream_test_clock_oe_n_out              = st_ff.downstream_test_clock_oe_n;
	assign downstream_mode_select_out = st_ff.dms;
	assign dms_oe_n_out               = st_ff.dms_oe_n;
	assign downstream_data_out        = st_ff.ddo;
	assign ddo_oe_n_out               = st_ff.ddo_oe_n;
	assign pin_force_out              = st_ff.pin_capture_chain;
	assign count_end_n_out            = st_ff.ce_n;
	assign condition_output_out       = st_ff.condition_output;
	assign preload_ready_out          = (st_ff.fill != 2'h2);

	////////////////////////////////////////////////////////////////////
	property p_ps_reset;
		@(posedge clk_sys_in) $fell(reset_in) |-> st_ff.ps == 8'h00;
	endproperty
	a_ps_reset: assert property (p_ps_reset)
		else $error("path select not cleared by reset");

	property p_byp_reset;
		@(posedge clk_sys_in)
		$fell(reset_in) |-> st_ff.sel == sld_pkg::SEL_BYP;
	endproperty
	a_byp_reset: assert property (p_byp_reset)
		else $error("bypass not selected after reset");

	property p_ddo_shift;
		@(posedge clk_sys_in) disable iff (reset_in)
		!(&ddo_oe_n_out) |-> $past(sh_any) && !$past(ctl[0]);
	endproperty
	a_ddo_shift: assert property (p_ddo_shift)
		else $error("data out driven outside shift states");

	property p_off;
		@(posedge clk_sys_in) disable iff (reset_in)
		ctl[0] |=> downstream_test_clock_oe_n_out && dms_oe_n_out && (&ddo_oe_n_out);
	endproperty
	a_off: assert property (p_off)
		else $error("downstream pins not floated");

	property p_byp_cap;
		@(posedge clk_sys_in) disable iff (reset_in)
		t_rise && tap_state_in == sld_pkg::TAP_CAPDR
			&& st_ff.sel == sld_pkg::SEL_BYP |=> !st_ff.bp;
	endproperty
	a_byp_cap: assert property (p_byp_cap)
		else $error("bypass did not capture zero");

	property p_first_low;
		@(posedge clk_sys_in) disable iff (reset_in)
		st_ff.pend[0] |=> !downstream_mode_select_out[0];
	endproperty
	a_first_low: assert property (p_first_low)
		else $error("new follower not held low");

	// checker copy of the bit entering path one; no long repetition
	logic chk_in_ff = 1'b0;
	always_ff @(posedge clk_sys_in) begin
		if (t_rise) begin
			chk_in_ff <= link[0];
		end
	end

	property p_delay;
		@(posedge clk_sys_in) disable iff (reset_in)
		t_fall && en[0] |=> downstream_data_out[0] == chk_in_ff;
	endproperty
	a_delay: assert property (p_delay)
		else $error("data out delay not one flop");

	property p_hold;
		@(posedge clk_sys_in) disable iff (reset_in)
		hold0 && !drain |=> st_ff.cnt == 8'h00;
	endproperty
	a_hold: assert property (p_hold)
		else $error("counter left zero while holding");

	property p_cnt_up;
		@(posedge clk_sys_in) disable iff (reset_in)
		cnt_ev && !down && !drain
			|=> st_ff.cnt == $past(st_ff.cnt) + 8'h01;
	endproperty
	a_cnt_up: assert property (p_cnt_up)
		else $error("counter did not step up");

	property p_end_up;
		@(posedge clk_sys_in) disable iff (reset_in)
		st_ff.cnt == 8'hFF && !down ##1 !down |-> !count_end_n_out;
	endproperty
	a_end_up: assert property (p_end_up)
		else $error("count end flag missing at all ones");

	property p_static_lvl;
		@(posedge clk_sys_in) disable iff (reset_in)
		t_fall && tap_state_in == sld_pkg::TAP_UPDDR
			&& st_ff.sel == sld_pkg::SEL_PATH && !st_ff.ps_sh[1]
			|-> ##2 downstream_mode_select_out[0]
				== !$past(st_ff.ps_sh[0], 2);
	endproperty
	a_static_lvl: assert property (p_static_lvl)
		else $error("static mode-select level not applied");

	property p_cnt_dn;
		@(posedge clk_sys_in) disable iff (reset_in)
		cnt_ev && down && !hold0 && !drain
			|=> st_ff.cnt == $past(st_ff.cnt) - 8'h01;
	endproperty
	a_cnt_dn: assert property (p_cnt_dn)
		else $error("counter did not step down");

	property p_preload;
		@(posedge clk_sys_in) disable iff (reset_in)
		push && st_ff.fill == 2'h0 ##1 !cnt_ev
			|=> st_ff.cnt == $past(st_ff.cnt_sh, 2);
	endproperty
	a_preload: assert property (p_preload)
		else $error("counter preload not taken");

	property p_tdo_idle;
		@(posedge clk_sys_in) disable iff (reset_in)
		t_fall && !sh_any |=> tdo_oe_n_out && $stable(tdo_out);
	endproperty
	a_tdo_idle: assert property (p_tdo_idle)
		else $error("tdo moved outside shift states");
endmodule : sld_linker

/* File: hw/sld_pkg.sv */
// Purpose: constants and state types for the scan linker data registers
// Assumes: 1149.1 state codes arrive from the tap logic of this device
// Notes:   pin vector indices, control bit positions, reset values
package sld_pkg;
	// tap states, standard 1149.1 encoding
	localparam logic [3:0] TAP_RTI   = 4'hC;
	localparam logic [3:0] TAP_CAPDR = 4'h6;
	localparam logic [3:0] TAP_SHDR  = 4'h2;
	localparam logic [3:0] TAP_UPDDR = 4'h5;
	localparam logic [3:0] TAP_SHIR  = 4'hA;
	localparam logic [3:0] TAP_UPDIR = 4'hD;

	// control chain bit positions
	localparam int CTL_OFF   = 0;
	localparam int CTL_DCIP  = 1;
	localparam int CTL_SRC0  = 5;
	localparam int CTL_SRC1  = 6;
	localparam int CTL_POL   = 7;
	localparam int CTL_HOLD  = 8;
	localparam int CTL_DOWN  = 9;

	// synchronised pin vector layout
	localparam int P_TCK  = 0;
	localparam int P_TMS  = 1;
	localparam int P_TDI  = 2;
	localparam int P_CND  = 3;
	localparam int P_DDI  = 4;
	localparam int P_CAP  = 8;
	localparam int PIN_W  = 18;

	localparam int NPATH  = 4;
	localparam int PS_W   = 8;
	localparam int PIN_CW = 10;
	localparam int IDB_W  = 4;
	localparam int CNT_W  = 8;

	localparam logic [PS_W-1:0]  PS_RST  = 8'h00;
	localparam logic [CNT_W-1:0] CNT_MAX = 8'hFF;
	localparam logic [CNT_W-1:0] CNT_MIN = 8'h00;
	localparam logic [NPATH-1:0] LVL_RST = 4'hF;

	typedef enum logic [2:0] {
		SEL_BYP, SEL_PATH, SEL_PIN, SEL_IDB, SEL_CNT, SEL_EXT
	} sld_sel_e;

	typedef struct packed {
		logic [PIN_W-1:0]            s1;
		logic [PIN_W-1:0]            s2;
		logic [PIN_W-1:0]            s3;
		logic [PIN_W-1:0]            flt;
		logic [1:0]                  pv;
		sld_sel_e                    sel;
		logic [PS_W-1:0]             ps_sh;
		logic [PS_W-1:0]             ps;
		logic [NPATH-1:0]            lvl;
		logic [NPATH-1:0]            fol;
		logic [NPATH-1:0]            pend;
		logic [NPATH-1:0]            stg;
		logic                        bp;
		logic [PIN_CW-1:0]           bsr_sh;
		logic [PIN_CW-1:0]           pin_capture_chain;
		logic [CNT_W-1:0]            cnt_sh;
		logic [CNT_W-1:0]            cnt;
		logic [1:0][CNT_W-1:0]       bufm;
		logic                        wp;
		logic                        rp;
		logic [1:0]                  fill;
		logic                        tdo;
		logic                        tdo_oe_n;
		logic [NPATH-1:0]            dms;
		logic                        dms_oe_n;
		logic [NPATH-1:0]            ddo;
		logic [NPATH-1:0]            ddo_oe_n;
		logic                        downstream_test_clock;
		logic                        downstream_test_clock_oe_n;
		logic                        ce_n;
		logic                        condition_output;
	} sld_st_s;
endpackage : sld_pkg

/* File: testbench/sld_chain_model.sv */
// Purpose: behavioural model of the four downstream scan chains
// Assumes: a chain shifts on rising test clock while its data is driven
// Notes:   a released return line toggles so a stale bit never passes
`timescale 1ns/100ps
module sld_chain_model #(
	parameter int LEN = 3
) (
	input  wire logic       downstream_test_clock_in,
	input  wire logic [3:0] ddo_in,
	input  wire logic [3:0] ddo_oe_n_in,
	output logic      [3:0] ddi_out
);
	logic [3:0][LEN-1:0] chain_ff = '0;
	initial ddi_out = 4'h0;
	////////////////////////////////////////////////////////////////////
	always @(posedge downstream_test_clock_in) begin
		for (int i = 0; i < 4; i++) begin
			if (!ddo_oe_n_in[i]) begin
				chain_ff[i] <= {ddo_in[i], chain_ff[i][LEN-1:1]};
			end
		end
	end
	always @(negedge downstream_test_clock_in) begin
		for (int i = 0; i < 4; i++) begin
			ddi_out[i] <= ddo_oe_n_in[i] ? ~ddi_out[i] : chain_ff[i][0];
		end
	end
endmodule : sld_chain_model

/* File: testbench/tb.sv */
// Purpose: self-checking bench of the scan linker data registers
// Assumes: tap states are driven directly, tck high and low 8 clk
// Notes:   fixed seed; paths 2..4 stay static to keep chain length known
`timescale 1ns/100ps
module tb;
	localparam int         LEN   = 3;
	localparam logic [3:0] E1_DR = 4'h1;
	localparam logic [3:0] E1_IR = 4'h9;
	logic clk_sys_in = 1'h0, reset_in = 1'h1, tck_in = 1'h0;
	logic tms_in = 1'h1, tdi_in = 1'h0, condition_input_in = 1'h0;
	logic [3:0] downstream_data_in, tap_state_in = sld_pkg::TAP_RTI;
	logic [9:0] pin_capture_in = 10'h000, control_chain_in = 10'h042;
	sld_pkg::sld_sel_e dr_sel_in = sld_pkg::SEL_BYP;
	logic tdo_out, tdo_oe_n_out, downstream_test_clock, downstream_test_clock_oe_n_out, dms_oe_n_out;
	logic count_end_n_out, condition_output_out, preload_ready_out;
	logic [3:0] downstream_mode_select_out, downstream_data_out;
	logic [3:0] ddo_oe_n_out;
	logic [4:0] oe_sh;
	logic [9:0] pin_force_out;
	logic [15:0] din, dout, msk;
	logic [7:0] v, cv, s;
	int failures = 0, total_checks = 0, k, n;
	always #25 clk_sys_in = ~clk_sys_in;
	////////////////////////////////////////////////////////////////////
	sld_linker dut (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
		.tck_in(tck_in), .tms_in(tms_in), .tdi_in(tdi_in),
		.condition_input_in(condition_input_in),
		.downstream_data_in(downstream_data_in),
		.pin_capture_in(pin_capture_in), .tap_state_in(tap_state_in),
		.dr_sel_in(dr_sel_in), .control_chain_in(control_chain_in),
		.ext_tdo_in(1'h0), .tdo_out(tdo_out), .tdo_oe_n_out(tdo_oe_n_out),
		.downstream_test_clock_out(downstream_test_clock), .downstream_test_clock_oe_n_out(downstream_test_clock_oe_n_out),
		.downstream_mode_select_out(downstream_mode_select_out),
		.dms_oe_n_out(dms_oe_n_out),
		.downstream_data_out(downstream_data_out),
		.ddo_oe_n_out(ddo_oe_n_out), .pin_force_out(pin_force_out),
		.count_end_n_out(count_end_n_out),
		.condition_output_out(condition_output_out),
		.preload_ready_out(preload_ready_out));
	sld_chain_model #(.LEN(LEN)) chains (.downstream_test_clock_in(downstream_test_clock),
		.ddo_in(downstream_data_out), .ddo_oe_n_in(ddo_oe_n_out),
		.ddi_out(downstream_data_in));
	////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] cnt_after(logic [7:0] c, int m,
		logic dn, logic hold);
		for (int i = 0; i < m; i++) begin
			if (!(dn && hold && c == 8'h00)) begin
				c = dn ? c - 8'h01 : c + 8'h01;
			end
		end
		return c;
	endfunction : cnt_after
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic conclude();
		if (failures == 0 && total_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : conclude
	// tap state moves between edges so the filtered edges see it stable
	task automatic tck(input logic [3:0] nxt, input logic di);
		tdi_in <= di;
		tck_in <= 1'h1;
		repeat (6) @(posedge clk_sys_in);
		tap_state_in <= nxt;
		repeat (2) @(posedge clk_sys_in);
		tck_in <= 1'h0;
		repeat (8) @(posedge clk_sys_in);
	endtask : tck
	task automatic scan(input int m, input logic [15:0] d,
		output logic [15:0] q, input logic go_idle);
		q = 16'h0000;
		tap_state_in <= sld_pkg::TAP_CAPDR;
		@(posedge clk_sys_in);
		tck(sld_pkg::TAP_SHDR, 1'h0);
		for (int i = 0; i < m; i++) begin
			q[i] = tdo_out;
			if (i == 0) oe_sh = {tdo_oe_n_out, ddo_oe_n_out};
			tck((i == m - 1) ? E1_DR : sld_pkg::TAP_SHDR, d[i]);
		end
		tck(sld_pkg::TAP_UPDDR, 1'h0);
		if (go_idle) tck(sld_pkg::TAP_RTI, 1'h0);
	endtask : scan
	task automatic sel_dr(input sld_pkg::sld_sel_e e);
		dr_sel_in <= e;
		tap_state_in <= E1_IR;
		@(posedge clk_sys_in);
		tck(sld_pkg::TAP_UPDIR, 1'h0);
		tck(sld_pkg::TAP_RTI, 1'h0);
	endtask : sel_dr
	task automatic pulse(input int m);
		repeat (m) begin
			condition_input_in <= 1'h1;
			repeat (5) @(posedge clk_sys_in);
			condition_input_in <= 1'h0;
			repeat (5) @(posedge clk_sys_in);
		end
	endtask : pulse
	////////////////////////////////////////////////////////////////////
	initial begin
		repeat (60000) @(posedge clk_sys_in);
		failures++;
		conclude();
	end
	initial begin
		k = $urandom(32'h5976);
		repeat (12) @(posedge clk_sys_in);
		reset_in <= 1'h0;
		repeat (4) @(posedge clk_sys_in);
		chk(ddo_oe_n_out, 16'h000F);
		chk(downstream_mode_select_out, 16'h000F);
		chk(preload_ready_out, 16'h0001);
		din = 16'($urandom);
		scan(16, din, dout, 1'h1);
		chk(dout[0], 16'h0000);
		chk(dout[15:1], din[14:0]);
		sel_dr(sld_pkg::SEL_PATH);
		s = {1'h0, 1'($urandom), 1'h0, 1'($urandom), 1'h0, 1'($urandom),
			2'h2};
		scan(8, {8'h00, s}, dout, 1'h0);
		chk(dout[7:0], 16'h0000);
		chk(downstream_mode_select_out, {~s[6], ~s[4], ~s[2], 1'h0});
		tck(sld_pkg::TAP_RTI, 1'h0);
		repeat (6) @(posedge clk_sys_in);
		chk(downstream_mode_select_out[0], 16'h0001);
		sel_dr(sld_pkg::SEL_BYP);
		din = 16'($urandom);
		scan(16, din, dout, 1'h1);
		chk(dout[15:LEN+2], din[13-LEN:0]);
		chk(oe_sh, 16'h000E);
		chk({tdo_oe_n_out, ddo_oe_n_out}, 16'h001F);
		control_chain_in[0] <= 1'h1;
		repeat (4) @(posedge clk_sys_in);
		chk({downstream_test_clock_oe_n_out, dms_oe_n_out}, 16'h0003);
		control_chain_in[0] <= 1'h0;
		// path one still linked: extra bits push zeros through its delay
		sel_dr(sld_pkg::SEL_PATH);
		scan(LEN + 10, 16'h0000, dout, 1'h1);
		chk(dout[7:0], s);
		chk(downstream_mode_select_out, 16'h000F);
		for (int j = 0; j < 2; j++) begin
			n = j ? 4 : 10;
			if (j == 0) sel_dr(sld_pkg::SEL_PIN);
			else sel_dr(sld_pkg::SEL_IDB);
			pin_capture_in <= 10'($urandom);
			din = 16'($urandom);
			msk = (16'h0001 << n) - 16'h0001;
			repeat (6) @(posedge clk_sys_in);
			scan(n, din, dout, 1'h1);
			chk(dout & msk, {6'h00, pin_capture_in} & msk);
			if (j == 0) chk(pin_force_out, din[9:0]);
		end
		sel_dr(sld_pkg::SEL_CNT);
		for (int j = 0; j < 4; j++) begin
			v = (j == 3) ? 8'hFE : 8'($urandom);
			k = (j == 3) ? 1 : 1 + $urandom % 5;
			scan(8, {8'h00, v}, dout, 1'h1);
			if (j > 0) chk(dout[7:0], cv);
			repeat (6) @(posedge clk_sys_in);
			pulse(k);
			cv = cnt_after(v, k, 1'h0, 1'h0);
		end
		repeat (4) @(posedge clk_sys_in);
		chk(count_end_n_out, 16'h0000);
		chk(condition_output_out, 16'h0000);
		control_chain_in[9:8] <= 2'h3;
		scan(8, 16'h0002, dout, 1'h1);
		chk(dout[7:0], cv);
		repeat (6) @(posedge clk_sys_in);
		chk(count_end_n_out, 16'h0001);
		pulse(4);
		chk(count_end_n_out, 16'h0000);
		scan(8, 16'h0000, dout, 1'h1);
		chk(dout[7:0], cnt_after(8'h02, 4, 1'h1, 1'h1));
		// falling edge counting, then a reset in mid-run
		control_chain_in <= 10'h040;
		v = 8'($urandom);
		k = 1 + $urandom % 5;
		scan(8, {8'h00, v}, dout, 1'h1);
		repeat (6) @(posedge clk_sys_in);
		pulse(k);
		msk = {6'h00, pin_force_out};
		reset_in <= 1'h1;
		repeat (3) @(posedge clk_sys_in);
		reset_in <= 1'h0;
		repeat (4) @(posedge clk_sys_in);
		chk(pin_force_out, msk);
		chk(preload_ready_out, 16'h0001);
		sel_dr(sld_pkg::SEL_CNT);
		scan(8, 16'h0000, dout, 1'h1);
		chk(dout[7:0], cnt_after(v, k, 1'h0, 1'h0));
		conclude();
	end
endmodule : tb
